/* File: core/ros_one_shot.sv */
// Retriggerable one-shot timer core
`timescale 1ns/10ps
`default_nettype none
module ros_one_shot #(
    parameter bit FIRE_RISING   = 1'b1,
    parameter bit RETRIGGERABLE = 1'b0,
    parameter int STARTUP_BASE  = ros_pkg::STARTUP_PERIODS
) (
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire logic       fire_input_in,
    input  wire logic [3:0] ratio_code_in,
    input  wire logic [4:0] rset_units_in,
    output var  logic       pulse_out,
    output var  logic       active_out,
    output var  logic       ready_out
);
    if (STARTUP_BASE < 1 || STARTUP_BASE >= (1 << ros_pkg::START_CNT_W)) begin : g_chk
        $error("STARTUP_BASE out of range");
    end

    // Three-stage input synchronisers
    logic [2:0] fire_sync;
    logic [2:0] code_sync [4];
    logic       fire_lvl;
    logic [3:0] code_lvl;
    logic       next_fire_lvl;
    logic [3:0] next_code_lvl;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fire_sync <= 3'h0;
        end else begin
            fire_sync <= {fire_sync[1:0], fire_input_in};
        end
    end

    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_code
        always_ff @(posedge mclk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                code_sync[gi] <= 3'h0;
            end else begin
                code_sync[gi] <= {code_sync[gi][1:0], ratio_code_in[gi]};
            end
        end
        always_comb begin
            next_code_lvl[gi] = code_lvl[gi];
            if (code_sync[gi][1] == code_sync[gi][2]) begin
                next_code_lvl[gi] = code_sync[gi][2];
            end
        end
    end

    always_comb begin
        next_fire_lvl = fire_lvl;
        if (fire_sync[1] == fire_sync[2]) begin
            next_fire_lvl = fire_sync[2];
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fire_lvl <= FIRE_RISING ? 1'b1 : 1'b0;
            code_lvl <= 4'h0;
        end else begin
            fire_lvl <= next_fire_lvl;
            code_lvl <= next_code_lvl;
        end
    end

    // One event per qualifying edge
    logic fire_evt;
    assign fire_evt = FIRE_RISING ? (next_fire_lvl & ~fire_lvl)
                                  : (~next_fire_lvl & fire_lvl);

    // Base period in clock cycles, resistor clamped to its span
    logic [4:0]                          units;
    logic [ros_pkg::BASE_CNT_W-1:0]      base_len;
    always_comb begin
        units = rset_units_in;
        if (rset_units_in < 5'(ros_pkg::UNITS_MIN)) begin
            units = 5'(ros_pkg::UNITS_MIN);
        end else if (rset_units_in > 5'(ros_pkg::UNITS_MAX)) begin
            units = 5'(ros_pkg::UNITS_MAX);
        end
        base_len = ros_pkg::BASE_CNT_W'(units * ros_pkg::BASE_MIN_CYC);
    end

    // Held ratio code and prescale factor
    ros_pkg::ros_ratio_t ratio;
    ros_pkg::ros_ratio_t next_ratio;
    logic [2:0]                   step;
    logic [ros_pkg::DIV_W-1:0]    div_last;
    always_comb begin
        step     = ratio.invert ? ~ratio.step : ratio.step;
        div_last = (ros_pkg::DIV_W'(1) << (step * ros_pkg::STEP_SHIFT))
                   - ros_pkg::DIV_W'(1);
    end

    // Timing state
    ros_pkg::ros_state_t             state;
    ros_pkg::ros_state_t             next_state;
    logic [ros_pkg::BASE_CNT_W-1:0]  base_cnt;
    logic [ros_pkg::BASE_CNT_W-1:0]  next_base_cnt;
    logic [ros_pkg::DIV_W-1:0]       div_cnt;
    logic [ros_pkg::DIV_W-1:0]       next_div_cnt;
    logic [ros_pkg::START_CNT_W-1:0] start_cnt;
    logic [ros_pkg::START_CNT_W-1:0] next_start_cnt;
    logic                            next_pulse;
    logic                            base_tick;

    assign base_tick = (base_cnt == base_len - ros_pkg::BASE_CNT_W'(1));

    always_comb begin
        next_state     = state;
        next_base_cnt  = base_tick ? '0 : base_cnt + ros_pkg::BASE_CNT_W'(1);
        next_div_cnt   = div_cnt;
        next_start_cnt = start_cnt;
        next_ratio     = ratio;
        case (state)
            ros_pkg::ST_START: begin
                if (base_tick) begin
                    if (start_cnt == ros_pkg::START_CNT_W'(STARTUP_BASE - 1)) begin
                        next_state = ros_pkg::ST_IDLE;
                        next_ratio = ros_pkg::ros_ratio_t'(code_lvl);
                    end else begin
                        next_start_cnt = start_cnt + ros_pkg::START_CNT_W'(1);
                    end
                end
            end
            ros_pkg::ST_IDLE: begin
                next_base_cnt = '0;
                next_div_cnt  = '0;
                if (fire_evt) begin
                    next_state = ros_pkg::ST_PULSE;
                end
            end
            ros_pkg::ST_PULSE: begin
                if (fire_evt && RETRIGGERABLE) begin
                    next_base_cnt = '0;
                    next_div_cnt  = '0;
                end else if (base_tick) begin
                    if (div_cnt == div_last) begin
                        next_state    = RETRIGGERABLE ? ros_pkg::ST_IDLE
                                                      : ros_pkg::ST_ARM;
                        next_base_cnt = '0;
                        next_div_cnt  = '0;
                    end else begin
                        next_div_cnt = div_cnt + ros_pkg::DIV_W'(1);
                    end
                end
            end
            ros_pkg::ST_ARM: begin
                next_base_cnt = '0;
                next_state    = ros_pkg::ST_IDLE;
            end
            default: begin
                next_state    = ros_pkg::ST_START;
                next_base_cnt = '0;
            end
        endcase
        next_pulse = (next_state == ros_pkg::ST_PULSE) ^ next_ratio.invert;
        if (next_state == ros_pkg::ST_START) begin
            next_pulse = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state     <= ros_pkg::ST_START;
            base_cnt  <= '0;
            div_cnt   <= '0;
            start_cnt <= '0;
            ratio     <= '0;
            pulse_out <= 1'b0;
        end else begin
            state     <= next_state;
            base_cnt  <= next_base_cnt;
            div_cnt   <= next_div_cnt;
            start_cnt <= next_start_cnt;
            ratio     <= next_ratio;
            pulse_out <= next_pulse;
        end
    end

    assign active_out = (state == ros_pkg::ST_PULSE);
    assign ready_out  = (state == ros_pkg::ST_IDLE);
endmodule : ros_one_shot
`default_nettype wire

/* File: inc/ros_pkg.sv */
// Shared constants and types for the retriggerable one-shot timer
package ros_pkg;
    localparam int MCLK_NS          = 25;
    localparam int BASE_MIN_NS      = 1000;
    localparam int BASE_MIN_CYC     = (BASE_MIN_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int RSET_UNIT_KOHM   = 50;
    localparam int RSET_MIN_KOHM    = 50;
    localparam int RSET_MAX_KOHM    = 800;
    localparam int UNITS_MIN        = RSET_MIN_KOHM / RSET_UNIT_KOHM;
    localparam int UNITS_MAX        = RSET_MAX_KOHM / RSET_UNIT_KOHM;
    localparam int BASE_CNT_W       = 10;
    localparam int STEP_SHIFT       = 3;
    localparam int DIV_W            = 22;
    localparam int STARTUP_PERIODS  = 500;
    localparam int START_CNT_W      = 16;
    localparam int ARM_CYC          = 1;
    localparam int REFIRE_UNIT_NS   = 10;
    localparam int REFIRE_SCALED_NS = 50;
    localparam int INVERT_POS       = 3;

    typedef struct packed {
        logic       invert;
        logic [2:0] step;
    } ros_ratio_t;

    typedef enum logic [3:0] {
        ST_START = 4'h1,
        ST_IDLE  = 4'h2,
        ST_PULSE = 4'h4,
        ST_ARM   = 4'h8
    } ros_state_t;
endpackage : ros_pkg

/* File: sim/ros_fire_src.sv */
// Trigger source model driving the fire pin
`timescale 1ns/10ps
`default_nettype none
module ros_fire_src (
    input  wire logic mclk_in,
    input  wire logic req_in,
    output var  logic fire_out
);
    logic [2:0] hold = 3'h0;
    always @(negedge mclk_in) begin
        if (hold != 3'h0) hold <= hold - 3'h1;
        else if (req_in) hold <= 3'h7;
    end
    always_comb fire_out = hold[2];
endmodule : ros_fire_src
`default_nettype wire

/* File: sim/ros_one_shot_monitor.sv */
// Port checker for the one-shot timer
`timescale 1ns/10ps
`default_nettype none
module ros_one_shot_monitor #(parameter bit RETRIGGERABLE = 1'b0) (
    input wire logic       mclk_in,
    input wire logic       rstn_in,
    input wire logic       fire_input_in,
    input wire logic [3:0] ratio_code_in,
    input wire logic [4:0] rset_units_in,
    input wire logic       pulse_out,
    input wire logic       active_out,
    input wire logic       ready_out
);
    logic [31:0] run;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) run <= 32'h0;
        else run <= active_out ? run + 32'h1 : 32'h0;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_rearm; !ready_out ##1 ready_out; endsequence
    AST_RST_QUIET: assert property (disable iff (1'b0)
        !rstn_in |-> !pulse_out && !active_out && !ready_out) else $error("busy in reset");
    AST_START_HOLD: assert property ($rose(rstn_in) |-> (!ready_out && !pulse_out)[*8])
        else $error("start-up too short");
    AST_EXCL: assert property (active_out |-> !ready_out) else $error("ready in pulse");
    AST_FROM_IDLE: assert property ($rose(active_out) |-> $past(ready_out))
        else $error("pulse not from idle");
    AST_IDLE_LVL: assert property (ready_out |-> pulse_out == ratio_code_in[3])
        else $error("idle level wrong");
    AST_ACT_LVL: assert property (active_out |-> pulse_out != ratio_code_in[3])
        else $error("active level wrong");
    AST_MIN_LEN: assert property ($fell(active_out) |-> run >= 32'd40)
        else $error("pulse too short");
    AST_REARM: assert property ($fell(active_out) |->
        if (RETRIGGERABLE) ready_out else s_rearm) else $error("rearm wrong");
    AST_IDLE_HOLD: assert property (ready_out |=> ready_out || active_out)
        else $error("idle left");
endmodule : ros_one_shot_monitor
`default_nettype wire

/* File: sim/ros_one_shot_tb.sv */
// Self-checking bench for the one-shot timer
`timescale 1ns/10ps
`default_nettype none
module ros_one_shot_tb;
    logic       mclk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       req = 1'b0;
    logic       fire;
    logic [3:0] code = 4'h0;
    logic [4:0] units = 5'h01;
    logic       pulse_out;
    logic       active_out;
    logic       ready_out;
    logic       pulse2;
    logic       active2;
    logic       ready2;
    int         bad_count = 0;
    int         num_checks = 0;
    int         codes[8] = '{0, 1, 2, 3, 12, 13, 14, 15};
    int         ulist[8] = '{1, 1, 1, 1, 1, 1, 20, 16};
    initial forever #12.5 mclk_in = ~mclk_in;
    ros_fire_src src (.mclk_in(mclk_in), .req_in(req), .fire_out(fire));
    ros_one_shot #(.FIRE_RISING(1'b1), .RETRIGGERABLE(1'b0), .STARTUP_BASE(2)) dut (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .fire_input_in(fire),
        .ratio_code_in(code), .rset_units_in(units), .pulse_out(pulse_out),
        .active_out(active_out), .ready_out(ready_out));
    // Falling-edge retriggerable build sees the inverted fire pin
    ros_one_shot #(.FIRE_RISING(1'b0), .RETRIGGERABLE(1'b1), .STARTUP_BASE(2)) dut2 (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .fire_input_in(~fire),
        .ratio_code_in(code), .rset_units_in(units), .pulse_out(pulse2),
        .active_out(active2), .ready_out(ready2));
    task automatic stop_test();
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk_bit(logic got, logic exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t level %b exp %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_num(int got, int exp);
        num_checks++;
        if (got != exp) begin
            bad_count++;
            $display("CHECK FAILED %0t count %0d exp %0d", $time, got, exp);
        end
    endtask : chk_num
    task automatic run_code(int i);
        int n;
        int exp;
        exp = 40 * (ulist[i] > 16 ? 16 : ulist[i]);
        @(negedge mclk_in) rstn_in = 1'b0;
        code = 4'(codes[i]);
        units = 5'(ulist[i]);
        repeat (16) @(negedge mclk_in);
        rstn_in = 1'b1;
        n = 0;
        while (ready_out !== 1'b1 && n < 2000) @(negedge mclk_in) n++;
        chk_num(int'(n >= 2 * exp - 1 && n <= 2 * exp + 4), 1);
        chk_bit(pulse_out, code[3]);
        req <= 1'b1;
        @(negedge mclk_in) req <= 1'b0;
        n = 0;
        while (active_out !== 1'b1 && n < 20) @(negedge mclk_in) n++;
        chk_bit(pulse_out, ~code[3]);
        chk_bit(active2, 1'b1);
        chk_bit(pulse2, ~code[3]);
        exp = exp << (3 * (code[3] ? 15 - codes[i] : codes[i]));
        n = 0;
        while (active_out === 1'b1 && n < exp + 100) begin
            req <= (n == 10);
            @(negedge mclk_in) n++;
        end
        chk_num(n, exp);
        chk_bit(pulse_out, code[3]);
        while (active2 === 1'b1 && n < exp + 100) @(negedge mclk_in) n++;
        chk_num(n, exp + 15);
        chk_bit(pulse2, code[3]);
        chk_bit(ready2, 1'b1);
    endtask : run_code
    initial begin
        for (int i = 0; i < 8; i++) run_code(i);
        stop_test();
    end
    initial begin
        #2000000;
        bad_count++;
        stop_test();
    end
endmodule : ros_one_shot_tb
bind ros_one_shot ros_one_shot_monitor #(.RETRIGGERABLE(RETRIGGERABLE)) mon (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .fire_input_in(fire_input_in),
    .ratio_code_in(ratio_code_in), .rset_units_in(rset_units_in), .pulse_out(pulse_out),
    .active_out(active_out), .ready_out(ready_out));
`default_nettype wire
